// file: hdl/rdt_top.sv
// Five-channel reload down timer unit with register port and interrupt
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "rdt_params.svh"
module rdt_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Subclock pin, divided by 32 inside
    input wire logic subclk_pin,
    // Channel pins
    input wire logic [4:0] channel_input_pin,
    output logic [4:0] channel_output_pin,
    output logic [4:0] channel_output_pin_oe,
    // Interrupt requests
    output logic [4:0] irq_pulse,
    output logic irq
);
    localparam int NCH = `RDT_NUM_CH;

    logic [NCH-1:0] shared_start_register;
    logic [3:0] prescaler_control_register;
    logic [NCH-1:0] status_reg;
    logic [NCH-1:0] mask_reg;
    logic [NCH-1:0] gate_low_reg;
    logic [`RDT_MR_WIDTH-1:0] channel_mode_register [NCH];
    logic [15:0] count_q [NCH];
    logic [15:0] reload_q [NCH];
    logic [NCH-1:0] pin_q;
    logic [NCH-1:0] uf_q;
    logic [NCH-1:0] count_wr;
    logic [NCH-1:0] mode_wr;
    logic [NCH-1:0] cnt_tick;
    logic [NCH-1:0] gate_ok;
    logic [NCH-1:0] ev_tick;
    logic [NCH-1:0] in_meta_reg;
    logic [NCH-1:0] in_sync_reg;
    logic [NCH-1:0] in_last_reg;
    logic sub_meta_reg;
    logic sub_sync_reg;
    logic sub_last_reg;
    logic [4:0] sub_div_reg;
    logic subclock_div_thirty_two;
    logic [2:0] div8_reg;
    logic divide_by_eight_clock;
    logic [15:0] presc_cnt_reg;
    logic [15:0] presc_mask;
    logic prescaled_clock;
    logic undivided_peripheral_clock;
    logic [15:0] rdata_next;
    logic status_rd;

    // Register write decode for the per-channel blocks
    always_comb begin
        count_wr = '0;
        mode_wr = '0;
        for (int i = 0; i < NCH; i++) begin
            count_wr[i] = wr && (addr == `RDT_OFF_COUNT_BASE + 8'(i));
            mode_wr[i] = wr && (addr == `RDT_OFF_MODE_BASE + 8'(i));
        end
    end

    // Shared control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shared_start_register <= `RDT_RST_CH;
            prescaler_control_register <= `RDT_RST_PRESC;
            mask_reg <= `RDT_RST_CH;
            gate_low_reg <= `RDT_RST_CH;
        end else if (wr) begin
            case (addr)
                `RDT_OFF_START: shared_start_register <= wdata[NCH-1:0];
                `RDT_OFF_PRESC: prescaler_control_register <= wdata[3:0];
                `RDT_OFF_MASK: mask_reg <= wdata[NCH-1:0];
                `RDT_OFF_GATEPOL: gate_low_reg <= wdata[NCH-1:0];
                default: begin
                end
            endcase
        end
    end

    // Mode registers, one per channel
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!rst_n) begin
                channel_mode_register[i] <= `RDT_RST_MODE;
            end else if (mode_wr[i]) begin
                channel_mode_register[i] <= wdata[`RDT_MR_WIDTH-1:0];
            end
        end
    end

    // Pins are asynchronous: two flops before any use, third for edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
            in_last_reg <= '0;
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_last_reg <= 1'b0;
        end else begin
            in_meta_reg <= channel_input_pin;
            in_sync_reg <= in_meta_reg;
            in_last_reg <= in_sync_reg;
            sub_meta_reg <= subclk_pin;
            sub_sync_reg <= sub_meta_reg;
            sub_last_reg <= sub_sync_reg;
        end
    end

    // Subclock divider; the subclock must be well below half of clk
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sub_div_reg <= 5'h00;
        end else if (sub_sync_reg && !sub_last_reg) begin
            sub_div_reg <= sub_div_reg + 5'h01;
        end
    end
    assign subclock_div_thirty_two = sub_sync_reg && !sub_last_reg &&
        (sub_div_reg == `RDT_SUB_DIV_LAST);

    // Divide-by-8 and prescaler as one-cycle enables of clk
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div8_reg <= 3'h0;
            presc_cnt_reg <= 16'h0000;
        end else begin
            div8_reg <= div8_reg + 3'h1;
            presc_cnt_reg <= presc_cnt_reg + 16'h0001;
        end
    end
    assign undivided_peripheral_clock = 1'b1;
    assign divide_by_eight_clock = (div8_reg == `RDT_DIV8_LAST);
    assign presc_mask = ~(16'hFFFF << prescaler_control_register);
    // Setting zero gives an empty mask, so every cycle ticks
    assign prescaled_clock = ((presc_cnt_reg & presc_mask) == presc_mask);

    // Count clock and gate selection per channel
    always_comb begin
        cnt_tick = '0;
        gate_ok = '0;
        ev_tick = '0;
        for (int i = 0; i < NCH; i++) begin
            gate_ok[i] = in_sync_reg[i] ^ gate_low_reg[i];
            case (rdt_pkg::rdt_evsrc_type'(channel_mode_register[i][`RDT_MR_EVSRC_LSB +: 2]))
                rdt_pkg::ev_pin: begin
                    if (channel_mode_register[i][`RDT_MR_EDGE_BIT]) begin
                        ev_tick[i] = in_sync_reg[i] && !in_last_reg[i];
                    end else begin
                        ev_tick[i] = !in_sync_reg[i] && in_last_reg[i];
                    end
                end
                rdt_pkg::ev_prev: ev_tick[i] = uf_q[(i + NCH - 1) % NCH];
                rdt_pkg::ev_next: ev_tick[i] = uf_q[(i + 1) % NCH];
                default: ev_tick[i] = 1'b0;
            endcase
            if (channel_mode_register[i][1:0] == 2'b01) begin
                cnt_tick[i] = ev_tick[i];
            end else begin
                case (rdt_pkg::rdt_src_type'(channel_mode_register[i][`RDT_MR_SRC_LSB +: 2]))
                    rdt_pkg::src_undivided: cnt_tick[i] = undivided_peripheral_clock;
                    rdt_pkg::src_div8: cnt_tick[i] = divide_by_eight_clock;
                    rdt_pkg::src_prescaled: cnt_tick[i] = prescaled_clock;
                    default: cnt_tick[i] = subclock_div_thirty_two;
                endcase
            end
        end
    end

    // Five identical channels
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : ch
            rdt_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .mode(rdt_pkg::rdt_mode_type'(channel_mode_register[g][1:0])),
                .running(shared_start_register[g]),
                .gate_en(channel_mode_register[g][`RDT_MR_GATE_BIT]),
                .gate_ok(gate_ok[g]),
                .pulse_en(channel_mode_register[g][`RDT_MR_PULSE_BIT]),
                .tick(cnt_tick[g]),
                .wr_en(count_wr[g]),
                .wr_data(wdata),
                .count_reg(count_q[g]),
                .reload_reg(reload_q[g]),
                .pin_reg(pin_q[g]),
                .underflow_reg(uf_q[g])
            );
        end
    endgenerate
    assign channel_output_pin = pin_q;

    // Output enable follows the pulse output selection
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!rst_n) begin
                channel_output_pin_oe[i] <= 1'b0;
            end else begin
                channel_output_pin_oe[i] <= channel_mode_register[i][`RDT_MR_PULSE_BIT];
            end
        end
    end

    // Read mux; counter is shown live rather than the reload value
    always_comb begin
        rdata_next = 16'h0000;
        case (addr)
            `RDT_OFF_START: rdata_next = {11'h000, shared_start_register};
            `RDT_OFF_PRESC: rdata_next = {12'h000, prescaler_control_register};
            `RDT_OFF_STATUS: rdata_next = {11'h000, status_reg};
            `RDT_OFF_MASK: rdata_next = {11'h000, mask_reg};
            `RDT_OFF_GATEPOL: rdata_next = {11'h000, gate_low_reg};
            default: begin
                for (int i = 0; i < NCH; i++) begin
                    if (addr == `RDT_OFF_COUNT_BASE + 8'(i)) begin
                        rdata_next = count_q[i];
                    end
                    if (addr == `RDT_OFF_MODE_BASE + 8'(i)) begin
                        rdata_next = {6'h00, channel_mode_register[i]};
                    end
                end
            end
        endcase
    end
    assign status_rd = rd && (addr == `RDT_OFF_STATUS);

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? rdata_next : 16'h0000;
        end
    end

    // Sticky status: read clears, a same-cycle underflow still sets
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= `RDT_RST_CH;
        end else begin
            status_reg <= (status_rd ? `RDT_RST_CH : status_reg) | uf_q;
        end
    end

    // Interrupt outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
            irq_pulse <= '0;
        end else begin
            irq <= |(status_reg & mask_reg);
            irq_pulse <= uf_q;
        end
    end

    // Checks on channel 0, which stands for all five
    logic [1:0] m0;
    assign m0 = channel_mode_register[0][1:0];

    a_count_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd && addr == `RDT_OFF_COUNT_BASE |=> rdata == $past(count_q[0]))
        else $error("count read did not return live counter");

    a_stop_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        !shared_start_register[0] && !count_wr[0] && m0 != 2'b10
        |=> count_q[0] == $past(count_q[0]))
        else $error("stopped channel changed its counter");

    a_write_stopped: assert property (
        @(posedge clk) disable iff (!rst_n)
        count_wr[0] && !shared_start_register[0]
        |=> count_q[0] == $past(wdata) && reload_q[0] == $past(wdata))
        else $error("stopped write did not load counter and reload");

    a_write_running: assert property (
        @(posedge clk) disable iff (!rst_n)
        count_wr[0] && shared_start_register[0] && m0 == 2'b00
        && !channel_mode_register[0][`RDT_MR_GATE_BIT]
        |=> reload_q[0] == $past(wdata) && count_q[0] == (!$past(cnt_tick[0]) ? $past(count_q[0])
        : ($past(count_q[0]) == 16'h0000 ? $past(reload_q[0]) : $past(count_q[0]) - 16'h0001)))
        else $error("running write disturbed the counter");

    a_timer_dec: assert property (
        @(posedge clk) disable iff (!rst_n)
        m0 == 2'b00 && shared_start_register[0] && cnt_tick[0] && !count_wr[0]
        && !channel_mode_register[0][`RDT_MR_GATE_BIT] && count_q[0] != 16'h0000
        |=> count_q[0] == $past(count_q[0]) - 16'h0001)
        else $error("timer did not decrement by one");

    a_uf_reload: assert property (
        @(posedge clk) disable iff (!rst_n)
        m0 == 2'b00 && shared_start_register[0] && cnt_tick[0] && !count_wr[0]
        && !channel_mode_register[0][`RDT_MR_GATE_BIT] && count_q[0] == 16'h0000
        |=> count_q[0] == $past(reload_q[0]) && uf_q[0] ##1 irq_pulse[0] && status_reg[0])
        else $error("underflow did not reload and request interrupt");

    a_pulse_toggle: assert property (
        @(posedge clk) disable iff (!rst_n)
        uf_q[0] && m0 == 2'b00 && $past(channel_mode_register[0][`RDT_MR_PULSE_BIT])
        |-> pin_q[0] != $past(pin_q[0]))
        else $error("pulse output did not toggle at underflow");

    a_gate_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        m0 == 2'b00 && channel_mode_register[0][`RDT_MR_GATE_BIT] && !gate_ok[0]
        && !count_wr[0] |=> count_q[0] == $past(count_q[0]))
        else $error("closed gate let the counter move");

    a_presc_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        prescaler_control_register == 4'h0 |-> prescaled_clock)
        else $error("undivided prescaler setting missed a tick");

    a_irq_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        (status_reg & mask_reg) != 5'h00 |=> irq)
        else $error("unmasked status did not raise interrupt");

    a_irq_single: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq_pulse[0] |-> $past(uf_q[0]))
        else $error("interrupt pulse without underflow");

    c_timer_uf: cover property (@(posedge clk) disable iff (!rst_n)
        m0 == 2'b00 && uf_q[0]);
    c_event_uf: cover property (@(posedge clk) disable iff (!rst_n)
        m0 == 2'b01 && uf_q[0]);
    c_oneshot_end: cover property (@(posedge clk) disable iff (!rst_n)
        m0 == 2'b10 && $fell(pin_q[0]));
    c_pwm_period: cover property (@(posedge clk) disable iff (!rst_n)
        m0 == 2'b11 && $rose(pin_q[0]));
endmodule

// file: hdl/rdt_params.svh
// Offsets, field positions, reset values and timing counts of the timer unit
// How it works
// - Five identical channels, each with a two-bit mode field in its mode register.
// - Event counter mode counts pin edges or neighbour channel underflows.
// - One-shot mode drives one output pulse until the counter reaches zero.
// - PWM mode repeats the programmed high and low widths without software.
// - Timer mode counts undivided, divide-by-8, prescaled or subclock/32 clock.
// - Four-bit prescaler: zero passes clock, n divides by two to the n.
// - Timer mode decrements per count clock and reloads on underflow.
// - Underflow rate is count clock divided by programmed value plus one.
// - A channel counts only while its start bit is one; a one-shot can still decrement once after it clears.
// - Timer mode raises an interrupt request on every underflow.
// - With gate selected, the input pin level arms a one-shot and lets the counter of the other modes count or hold.
// - With pulse output selected, the output pin toggles at each underflow.
// - Reading a count register returns the live counter, not the reload.
// - Writing a stopped channel loads both reload register and counter.
// - Writing a running channel loads only the reload register.
// - Mode value one selects event counter mode.
`ifndef RDT_PARAMS_SVH
`define RDT_PARAMS_SVH
`define RDT_NUM_CH 5
`define RDT_OFF_START 8'h00
`define RDT_OFF_PRESC 8'h01
`define RDT_OFF_STATUS 8'h02
`define RDT_OFF_MASK 8'h03
`define RDT_OFF_GATEPOL 8'h04
`define RDT_OFF_COUNT_BASE 8'h10
`define RDT_OFF_MODE_BASE 8'h18
`define RDT_MR_MODE_LSB 0
`define RDT_MR_GATE_BIT 2
`define RDT_MR_PULSE_BIT 3
`define RDT_MR_SRC_LSB 4
`define RDT_MR_EDGE_BIT 6
`define RDT_MR_EVSRC_LSB 8
`define RDT_MR_WIDTH 10
`define RDT_RST_COUNT 16'h0000
`define RDT_RST_MODE 10'h000
`define RDT_RST_CH 5'h00
`define RDT_RST_PRESC 4'h0
`define RDT_DIV8_LAST 3'h7
`define RDT_SUB_DIV_LAST 5'h1F
`endif

// file: hdl/rdt_pkg.sv
// Types shared by the timer unit
package rdt_pkg;
    typedef enum logic [1:0] {
        mode_timer = 2'b00,
        mode_event = 2'b01,
        mode_oneshot = 2'b10,
        mode_pwm = 2'b11
    } rdt_mode_type;
    typedef enum logic [1:0] {
        src_undivided = 2'b00,
        src_div8 = 2'b01,
        src_prescaled = 2'b10,
        src_sub32 = 2'b11
    } rdt_src_type;
    typedef enum logic [1:0] {
        ev_pin = 2'b00,
        ev_prev = 2'b01,
        ev_next = 2'b10,
        ev_none = 2'b11
    } rdt_evsrc_type;
endpackage

// file: hdl/rdt_channel.sv
// One down-counting timer channel with reload, one-shot and PWM behaviour
`timescale 1ns/1ns
`include "rdt_params.svh"
module rdt_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire rdt_pkg::rdt_mode_type mode,
    input wire logic running,
    input wire logic gate_en,
    input wire logic gate_ok,
    input wire logic pulse_en,
    input wire logic tick,
    // Count register write
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // State
    output logic [15:0] count_reg,
    output logic [15:0] reload_reg,
    output logic pin_reg,
    output logic underflow_reg
);
    logic allowed;
    logic adv;
    logic zero;
    logic trigger;
    logic os_active_reg;
    logic os_done_reg;

    // Gate holds the counter; one-shot arms on start or gate level
    assign allowed = !gate_en || gate_ok;
    assign adv = running && tick && allowed;
    assign zero = (count_reg == 16'h0000);
    assign trigger = running && allowed && !os_active_reg && !os_done_reg;

    // Reload register takes every write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reload_reg <= `RDT_RST_COUNT;
        end else if (wr_en) begin
            reload_reg <= wr_data;
        end
    end

    // Counter; a write while running waits for the next reload
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= `RDT_RST_COUNT;
        end else if (wr_en && !running) begin
            count_reg <= wr_data;
        end else begin
            case (mode)
                rdt_pkg::mode_timer, rdt_pkg::mode_event: begin
                    if (adv) begin
                        count_reg <= zero ? reload_reg : count_reg - 16'h0001;
                    end
                end
                rdt_pkg::mode_oneshot: begin
                    if (trigger) begin
                        count_reg <= reload_reg;
                    end else if (os_active_reg && tick && !zero) begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                rdt_pkg::mode_pwm: begin
                    if (adv) begin
                        // Next phase high loads the width, low loads its complement
                        if (zero) begin
                            count_reg <= pin_reg ? ~reload_reg : reload_reg;
                        end else begin
                            count_reg <= count_reg - 16'h0001;
                        end
                    end
                end
                default: begin
                    count_reg <= count_reg;
                end
            endcase
        end
    end

    // One-shot sequencing: rearms only after the start bit is cleared or the mode leaves one-shot
    always_ff @(posedge clk) begin
        if (!rst_n || !running || mode != rdt_pkg::mode_oneshot) begin
            os_active_reg <= 1'b0;
            os_done_reg <= 1'b0;
        end else if (trigger) begin
            os_active_reg <= 1'b1;
        end else if (os_active_reg && tick && zero) begin
            os_active_reg <= 1'b0;
            os_done_reg <= 1'b1;
        end
    end

    // Output level and registered one-clock underflow pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_reg <= 1'b0;
            underflow_reg <= 1'b0;
        end else begin
            underflow_reg <= 1'b0;
            case (mode)
                rdt_pkg::mode_oneshot: begin
                    if (trigger) begin
                        pin_reg <= 1'b1;
                    end else if (os_active_reg && tick && zero) begin
                        pin_reg <= 1'b0;
                        underflow_reg <= 1'b1;
                    end
                end
                rdt_pkg::mode_pwm: begin
                    if (adv && zero) begin
                        pin_reg <= !pin_reg;
                        underflow_reg <= pin_reg;
                    end
                end
                default: begin
                    if (adv && zero) begin
                        underflow_reg <= 1'b1;
                        if (pulse_en) begin
                            pin_reg <= !pin_reg;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// file: tb/rdt_top_test.sv
// Self-checking bench for the five-channel reload down timer unit
`timescale 1ns/1ns
module rdt_top_test;
    // Design ports
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic subclk_pin = 1'b0;
    logic [4:0] channel_input_pin = 5'h00;
    logic [4:0] channel_output_pin;
    logic [4:0] channel_output_pin_oe;
    logic [4:0] irq_pulse;
    logic irq;
    // Bookkeeping shared by driver and watcher
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 75;
    int gap = 0;
    int n;
    int p;
    int i;
    logic [15:0] rd_q[$];
    int gap_q[$];
    logic rd_d = 1'b0;
    logic pulse_d = 1'b0;
    logic seen = 1'b0;
    logic exp_pin = 1'b0;
    logic mask_on = 1'b0;
    logic ev_run = 1'b0;

    // Clock and a slow unrelated subclock
    always #50 clk = ~clk;
    always #1730 subclk_pin = ~subclk_pin;

    rdt_top rdt_top_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .subclk_pin(subclk_pin), .channel_input_pin(channel_input_pin),
        .channel_output_pin(channel_output_pin),
        .channel_output_pin_oe(channel_output_pin_oe), .irq_pulse(irq_pulse), .irq(irq)
    );

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Strobes are held by the next access, so back-to-back never double-assigns
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        rd_q.push_back(exp);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
    endtask

    task automatic settle(input int k);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (k) @(posedge clk);
    endtask

    // Bounded wait until every expected gap has been seen
    task automatic drain();
        int j;
        settle(1);
        for (j = 0; j < 600 && gap_q.size() > 0; j++) @(posedge clk);
        // A missing pulse is a hang: count it and close the run
        if (gap_q.size() > 0) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // Late pulses from the final tick land before the gap tracker is cleared
    task automatic stop();
        wr_reg(8'h00, 16'h0000);
        settle(4);
        seen = 1'b0;
    endtask

    // Watcher: read data, pulse spacing, pin toggles, interrupt level, timeout
    always @(posedge clk) begin
        cycles++;
        if (rd_d && rd_q.size() > 0) cmp("rdata", rd_q.pop_front(), rdata);
        rd_d <= rd;
        if (pulse_d) cmp("irq", {15'h0000, mask_on}, {15'h0000, irq});
        pulse_d <= irq_pulse[0];
        gap++;
        if (irq_pulse[0] === 1'b1) begin
            exp_pin = ~exp_pin;
            cmp("pin", {15'h0000, exp_pin}, {15'h0000, channel_output_pin[0]});
            if (seen && gap_q.size() > 0) cmp("gap", 16'(gap_q.pop_front()), 16'(gap));
            seen = 1'b1;
            gap = 0;
        end
        if (ev_run && cycles % 4 == 0) channel_input_pin[0] <= ~channel_input_pin[0];
        if (cycles == 6000) begin
            mismatches++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Every place reads zero after reset, unmapped ones included
        for (i = 0; i < 32; i++) rd_reg(i[7:0], 16'h0000);
        mask_on = 1'b1;
        wr_reg(8'h03, 16'h0001);
        wr_reg(8'h18, 16'h0008);
        wr_reg(8'h10, 16'h0005);
        rd_reg(8'h10, 16'h0005);
        gap_q = '{6, 6};
        wr_reg(8'h00, 16'h0001);
        drain();
        cmp("oe", 16'h0001, {15'h0000, channel_output_pin_oe[0]});
        // Running write goes to reload only
        gap_q = '{6, 10, 10};
        wr_reg(8'h10, 16'h0009);
        drain();
        stop();
        wr_reg(8'h10, 16'h0003);
        settle(8);
        rd_reg(8'h10, 16'h0003);
        rd_reg(8'h02, 16'h0001);
        rd_reg(8'h02, 16'h0000);
        settle(3);
        cmp("irq idle", 16'h0000, {15'h0000, irq});
        // Random reloads over prescaled clocks, one pass with the mask off
        for (i = 0; i < 4; i++) begin
            n = {$random(seed)} % 8;
            p = {$random(seed)} % 3;
            mask_on = (i != 2);
            wr_reg(8'h03, {15'h0000, mask_on});
            wr_reg(8'h01, p[15:0]);
            wr_reg(8'h18, 16'h0028);
            wr_reg(8'h10, n[15:0]);
            gap_q = '{(n + 1) << p, (n + 1) << p};
            wr_reg(8'h00, 16'h0001);
            drain();
            stop();
        end
        // Gate closed holds the count, open lets it run
        wr_reg(8'h18, 16'h000C);
        wr_reg(8'h10, 16'h0004);
        wr_reg(8'h00, 16'h0001);
        settle(10);
        rd_reg(8'h10, 16'h0004);
        gap_q = '{5, 5};
        channel_input_pin[0] <= 1'b1;
        drain();
        stop();
        // Event mode counts rising pin edges, one every eight cycles
        wr_reg(8'h18, 16'h0049);
        wr_reg(8'h10, 16'h0002);
        gap_q = '{24, 24};
        wr_reg(8'h00, 16'h0001);
        ev_run = 1'b1;
        drain();
        ev_run = 1'b0;
        stop();
        // One-shot holds the pin high for reload plus one ticks
        wr_reg(8'h18, 16'h0002);
        wr_reg(8'h10, 16'h0003);
        wr_reg(8'h00, 16'h0001);
        exp_pin = 1'b1;
        settle(2);
        cmp("oneshot pin", 16'h0001, {15'h0000, channel_output_pin[0]});
        settle(6);
        cmp("oneshot pin", 16'h0000, {15'h0000, channel_output_pin[0]});
        stop();
        // Channel 1 counts the underflows of channel 0
        wr_reg(8'h18, 16'h0008);
        wr_reg(8'h10, 16'h0001);
        wr_reg(8'h19, 16'h0101);
        wr_reg(8'h11, 16'h0000);
        wr_reg(8'h00, 16'h0003);
        settle(8);
        stop();
        rd_reg(8'h02, 16'h0003);
        settle(2);
        cmp("gaps left", 16'h0000, 16'(gap_q.size()));
        wrap_up();
    end
endmodule
